// File: verilog/ssd_pkg.sv
// shared constants and carrier types for the management memory decoder
package ssd_pkg;
   localparam logic [31:0] COMPAT_LO    = 32'h000a_0000;
   localparam logic [31:0] COMPAT_HI    = 32'h000b_ffff;
   localparam logic [31:0] HIGH_LO      = 32'hfeda_0000;
   localparam logic [31:0] HIGH_HI      = 32'hfedb_ffff;
   localparam logic [31:0] HIGH_OFFSET  = 32'hfed0_0000;
   localparam logic [31:0] MB_1         = 32'h0010_0000;
   localparam logic [31:0] MB_2         = 32'h0020_0000;
   localparam logic [31:0] MB_8         = 32'h0080_0000;
   localparam int          NUM_WIN      = 5;
   localparam int          WIN_APERTURE = 1;

   // byte offsets on the register bus
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_TOP       = 8'h04;
   localparam logic [7:0] REG_STOLEN    = 8'h08;
   localparam logic [7:0] REG_STATUS    = 8'h0c;
   localparam logic [7:0] REG_WIN_BASE  = 8'h10;
   localparam logic [7:0] REG_WIN_MASK  = 8'h30;
   localparam logic [7:0] REG_WIN_LAST  = 8'h4c;
   localparam logic [1:0] RESP_OKAY     = 2'b00;
   localparam logic [1:0] RESP_SLVERR   = 2'b10;

   // control register field positions
   localparam int B_GLOBAL = 0;
   localparam int B_HIGH   = 1;
   localparam int B_TOP    = 2;
   localparam int B_CLOSE  = 3;
   localparam int B_OPEN   = 4;
   localparam int B_LOCK   = 5;
   localparam int B_VGA    = 6;
   localparam int B_MONO   = 7;
   localparam int B_GFX    = 8;
   localparam int B_TSZ    = 9;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      SSD_DEST_NORMAL = 3'b000,
      SSD_DEST_DRAM   = 3'b001,
      SSD_DEST_PEG    = 3'b010,
      SSD_DEST_SOUTH  = 3'b011,
      SSD_DEST_GFX    = 3'b100,
      SSD_DEST_REFUSE = 3'b101
   } ssd_dest_type;

   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic        from_cpu;
      logic        in_mgmt_mode;
      logic        is_code;
      logic        request_type_bit1;
   } ssd_req_type;

   typedef struct packed {
      logic         valid;
      ssd_dest_type dest;
      logic [31:0]  dram_addr;
      logic         write_combining_attr;
      logic [2:0]   window_hit;
   } ssd_resp_type;
endpackage

// File: verilog/ssd_decode.sv
// management memory space decoder with graphics windows, AXI4-Lite control
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ssd_decode (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output var  logic                 s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output var  logic                 s_axi_wready,
   output var  logic [1:0]           s_axi_bresp,
   output var  logic                 s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output var  logic                 s_axi_arready,
   output var  logic [31:0]          s_axi_rdata,
   output var  logic [1:0]           s_axi_rresp,
   output var  logic                 s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire ssd_pkg::ssd_req_type  req,
   output var  ssd_pkg::ssd_resp_type resp
);
   logic [31:0] ctrl, next_ctrl;
   logic [31:0] low_top, next_low_top;
   logic [31:0] stolen, next_stolen;
   logic [31:0] win_base [ssd_pkg::NUM_WIN];
   logic [31:0] win_mask [ssd_pkg::NUM_WIN];
   logic [31:0] next_win_base [ssd_pkg::NUM_WIN];
   logic [31:0] next_win_mask [ssd_pkg::NUM_WIN];
   logic [7:0]  hit_count, next_hit_count;
   logic [7:0]  refuse_count, next_refuse_count;
   logic        aw_held, next_aw_held;
   logic        w_held, next_w_held;
   logic [7:0]  aw_addr, next_aw_addr;
   logic [31:0] w_data, next_w_data;
   logic [3:0]  w_strb, next_w_strb;
   logic        next_bvalid, next_rvalid;
   logic [1:0]  next_bresp, next_rresp;
   logic [31:0] next_rdata;
   ssd_pkg::ssd_resp_type next_resp;

   // ---------------- register bus ----------------
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = val[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [2:0] win_index(input logic [7:0] a,
                                            input logic [7:0] b);
      logic [7:0] d;
      d = a - b;
      return d[4:2];
   endfunction

   logic do_write;
   logic [7:0] rd_addr;
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      do_write = aw_held && w_held && !s_axi_bvalid;
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
      end
      next_bvalid = s_axi_bvalid;
      next_bresp  = s_axi_bresp;
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      next_ctrl     = ctrl;
      next_low_top  = low_top;
      next_stolen   = stolen;
      next_win_base = win_base;
      next_win_mask = win_mask;
      if (do_write) begin
         next_bvalid = 1'b1;
         next_bresp  = ssd_pkg::RESP_OKAY;
         if (aw_addr == ssd_pkg::REG_CTRL) begin
            next_ctrl = merge(ctrl, w_data, w_strb);
         end else if (aw_addr == ssd_pkg::REG_TOP) begin
            next_low_top = merge(low_top, w_data, w_strb);
         end else if (aw_addr == ssd_pkg::REG_STOLEN) begin
            next_stolen = merge(stolen, w_data, w_strb);
         end else if (aw_addr >= ssd_pkg::REG_WIN_BASE &&
                      aw_addr <  ssd_pkg::REG_WIN_MASK &&
                      win_index(aw_addr, ssd_pkg::REG_WIN_BASE) <
                      3'(ssd_pkg::NUM_WIN) && aw_addr[1:0] == 2'h0) begin
            next_win_base[win_index(aw_addr, ssd_pkg::REG_WIN_BASE)] =
               merge(win_base[win_index(aw_addr, ssd_pkg::REG_WIN_BASE)],
                     w_data, w_strb);
         end else if (aw_addr >= ssd_pkg::REG_WIN_MASK &&
                      aw_addr <= ssd_pkg::REG_WIN_LAST &&
                      win_index(aw_addr, ssd_pkg::REG_WIN_MASK) <
                      3'(ssd_pkg::NUM_WIN) && aw_addr[1:0] == 2'h0) begin
            next_win_mask[win_index(aw_addr, ssd_pkg::REG_WIN_MASK)] =
               merge(win_mask[win_index(aw_addr, ssd_pkg::REG_WIN_MASK)],
                     w_data, w_strb);
         end else if (aw_addr != ssd_pkg::REG_STATUS) begin
            next_bresp = ssd_pkg::RESP_SLVERR;
         end
      end
      // reads
      rd_addr     = s_axi_araddr;
      next_rvalid = s_axi_rvalid;
      next_rdata  = s_axi_rdata;
      next_rresp  = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = ssd_pkg::RESP_OKAY;
         next_rdata  = 32'h0000_0000;
         if (rd_addr == ssd_pkg::REG_CTRL) begin
            next_rdata = ctrl;
         end else if (rd_addr == ssd_pkg::REG_TOP) begin
            next_rdata = low_top;
         end else if (rd_addr == ssd_pkg::REG_STOLEN) begin
            next_rdata = stolen;
         end else if (rd_addr == ssd_pkg::REG_STATUS) begin
            next_rdata = {16'h0000, refuse_count, hit_count};
         end else if (rd_addr >= ssd_pkg::REG_WIN_BASE &&
                      rd_addr <  ssd_pkg::REG_WIN_MASK &&
                      win_index(rd_addr, ssd_pkg::REG_WIN_BASE) <
                      3'(ssd_pkg::NUM_WIN) && rd_addr[1:0] == 2'h0) begin
            next_rdata = win_base[win_index(rd_addr, ssd_pkg::REG_WIN_BASE)];
         end else if (rd_addr >= ssd_pkg::REG_WIN_MASK &&
                      rd_addr <= ssd_pkg::REG_WIN_LAST &&
                      win_index(rd_addr, ssd_pkg::REG_WIN_MASK) <
                      3'(ssd_pkg::NUM_WIN) && rd_addr[1:0] == 2'h0) begin
            next_rdata = win_mask[win_index(rd_addr, ssd_pkg::REG_WIN_MASK)];
         end else begin
            next_rresp = ssd_pkg::RESP_SLVERR;
         end
      end
   end

   // ready only while nothing of that channel is held or answered
   always_ff @(posedge clk) begin
      if (rst) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_arready <= 1'b0;
      end else begin
         s_axi_awready <= !next_aw_held && !next_bvalid && !s_axi_awready;
         s_axi_wready  <= !next_w_held && !next_bvalid && !s_axi_wready;
         s_axi_arready <= !next_rvalid && !s_axi_arready;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl         <= ssd_pkg::CTRL_RESET;
         low_top      <= 32'h0000_0000;
         stolen       <= 32'h0000_0000;
         for (int i = 0; i < ssd_pkg::NUM_WIN; i++) begin
            win_base[i] <= 32'h0000_0000;
            win_mask[i] <= 32'h0000_0000;
         end
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= 2'b00;
      end else begin
         ctrl         <= next_ctrl;
         low_top      <= next_low_top;
         stolen       <= next_stolen;
         win_base     <= next_win_base;
         win_mask     <= next_win_mask;
         aw_held      <= next_aw_held;
         w_held       <= next_w_held;
         aw_addr      <= next_aw_addr;
         w_data       <= next_w_data;
         w_strb       <= next_w_strb;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp  <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rresp;
      end
   end

   // ---------------- decode ----------------
   logic        g_en, h_en, t_en, close_c, open_c, lock_c, vga_en, mono;
   logic        gfx_present;
   logic [31:0] t_size, t_end, t_start;
   logic        in_c, in_h, in_t, c_on, h_on, t_on;
   logic        code_ok, data_ok, allow, wb;
   logic [ssd_pkg::NUM_WIN-1:0] win_hit;
   assign g_en        = ctrl[ssd_pkg::B_GLOBAL];
   assign h_en        = ctrl[ssd_pkg::B_HIGH];
   assign t_en        = ctrl[ssd_pkg::B_TOP];
   assign close_c     = ctrl[ssd_pkg::B_CLOSE];
   assign open_c      = ctrl[ssd_pkg::B_OPEN];
   assign lock_c      = ctrl[ssd_pkg::B_LOCK];
   assign vga_en      = ctrl[ssd_pkg::B_VGA];
   assign mono        = ctrl[ssd_pkg::B_MONO];
   assign gfx_present = ctrl[ssd_pkg::B_GFX];

   always_comb begin
      case (ctrl[ssd_pkg::B_TSZ +: 2])
         2'b00:   t_size = ssd_pkg::MB_1;
         2'b01:   t_size = ssd_pkg::MB_2;
         default: t_size = ssd_pkg::MB_8;
      endcase
   end
   // top range sits just under graphics stolen memory when gfx_present is set, else just under low_top
   assign t_end   = gfx_present ? low_top - stolen : low_top;
   assign t_start = t_end - t_size;

   assign in_c = req.addr >= ssd_pkg::COMPAT_LO &&
                 req.addr <= ssd_pkg::COMPAT_HI;
   assign in_h = req.addr >= ssd_pkg::HIGH_LO && req.addr <= ssd_pkg::HIGH_HI;
   assign in_t = req.addr >= t_start && req.addr < t_end;
   assign c_on = g_en && !h_en;
   assign h_on = g_en && h_en;
   assign t_on = g_en && t_en;

   // open with close set is undefined; open simply wins here unless lock is set
   always_comb begin
      if (!g_en) begin
         code_ok = 1'b0;
         data_ok = 1'b0;
      end else if (lock_c || !open_c) begin
         code_ok = req.in_mgmt_mode;
         data_ok = req.in_mgmt_mode && !close_c;
      end else begin
         code_ok = 1'b1;
         data_ok = 1'b1;
      end
   end
   assign wb    = !req.request_type_bit1;
   assign allow = wb || (req.is_code ? code_ok : data_ok);

   for (genvar gi = 0; gi < ssd_pkg::NUM_WIN; gi++) begin : g_win
      assign win_hit[gi] = gfx_present && win_mask[gi] != 32'h0000_0000 &&
         ((req.addr & win_mask[gi]) == (win_base[gi] & win_mask[gi]));
   end

   always_comb begin
      next_resp       = '0;
      next_resp.valid = req.valid;
      next_resp.dest  = ssd_pkg::SSD_DEST_NORMAL;
      next_resp.dram_addr = req.addr;
      next_hit_count    = hit_count;
      next_refuse_count = refuse_count;
      if ((in_c && c_on) || (in_h && h_on) || (in_t && t_on)) begin
         if (!req.from_cpu) begin
            next_resp.dest = ssd_pkg::SSD_DEST_REFUSE;
         end else if (allow) begin
            next_resp.dest = ssd_pkg::SSD_DEST_DRAM;
            if (in_h) begin
               next_resp.dram_addr = req.addr - ssd_pkg::HIGH_OFFSET;
            end
         end else if (close_c && req.in_mgmt_mode && !in_t) begin
            next_resp.dest = (vga_en && !mono) ? ssd_pkg::SSD_DEST_PEG
                                               : ssd_pkg::SSD_DEST_SOUTH;
         end
      end else if (in_c && h_on && req.from_cpu) begin
         next_resp.dest = (vga_en && !mono) ? ssd_pkg::SSD_DEST_PEG
                                            : ssd_pkg::SSD_DEST_SOUTH;
      end else if (|win_hit) begin
         next_resp.dest = ssd_pkg::SSD_DEST_GFX;
         next_resp.write_combining_attr =
            win_hit[ssd_pkg::WIN_APERTURE];
      end
      for (int i = 0; i < ssd_pkg::NUM_WIN; i++) begin
         if (win_hit[i] && next_resp.dest == ssd_pkg::SSD_DEST_GFX) begin
            next_resp.window_hit = 3'(i);
         end
      end
      if (!req.valid) begin
         next_resp = '0;
      end
      if (next_resp.valid && next_resp.dest == ssd_pkg::SSD_DEST_DRAM) begin
         next_hit_count = hit_count + 8'h01;
      end
      if (next_resp.valid && next_resp.dest == ssd_pkg::SSD_DEST_REFUSE) begin
         next_refuse_count = refuse_count + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         resp         <= '0;
         hit_count    <= 8'h00;
         refuse_count <= 8'h00;
      end else begin
         resp         <= next_resp;
         hit_count    <= next_hit_count;
         refuse_count <= next_refuse_count;
      end
   end

   chk_refuse_downstream: assert property (
      @(posedge clk) disable iff (rst)
      req.valid && !req.from_cpu |=> resp.dest != ssd_pkg::SSD_DEST_DRAM)
      else $error("downstream master reached mgmt dram");
   chk_global_off: assert property (
      @(posedge clk) disable iff (rst)
      req.valid && !g_en && !(|win_hit) |=>
      resp.dest == ssd_pkg::SSD_DEST_NORMAL)
      else $error("mgmt decode active with global enable off");
   // resp belongs to the request one cycle earlier
   chk_high_remap: assert property (
      @(posedge clk) disable iff (rst)
      req.valid && in_h |=> resp.dest != ssd_pkg::SSD_DEST_DRAM ||
      resp.dram_addr == $past(req.addr) - ssd_pkg::HIGH_OFFSET)
      else $error("high range remap wrong");
   chk_writeback: assert property (
      @(posedge clk) disable iff (rst)
      req.valid && req.from_cpu && !req.request_type_bit1 && in_c && c_on
      |=> resp.dest == ssd_pkg::SSD_DEST_DRAM &&
          resp.dram_addr == $past(req.addr))
      else $error("writeback not sent to mgmt dram");
   chk_lock_mode: assert property (
      @(posedge clk) disable iff (rst)
      req.valid && req.from_cpu && lock_c && !req.in_mgmt_mode &&
      req.request_type_bit1 && in_c && c_on |=>
      resp.dest == ssd_pkg::SSD_DEST_NORMAL)
      else $error("lock let access outside mgmt mode");
   chk_open_access: assert property (
      @(posedge clk) disable iff (rst)
      req.valid && req.from_cpu && g_en && open_c && !lock_c && in_h && h_on
      |=> resp.dest == ssd_pkg::SSD_DEST_DRAM)
      else $error("open did not allow access");
   chk_close_data: assert property (
      @(posedge clk) disable iff (rst)
      req.valid && req.from_cpu && close_c && !open_c && req.in_mgmt_mode &&
      !req.is_code && req.request_type_bit1 && in_c && c_on |=>
      resp.dest inside {ssd_pkg::SSD_DEST_PEG, ssd_pkg::SSD_DEST_SOUTH})
      else $error("closed data access not routed out");
   chk_compat_fwd: assert property (
      @(posedge clk) disable iff (rst)
      req.valid && req.from_cpu && in_c && h_on && vga_en && !mono |=>
      resp.dest == ssd_pkg::SSD_DEST_PEG)
      else $error("compatible hit not forwarded to peg");
endmodule
`default_nettype wire

// File: tb/ssd_cpu_model.sv
// requester model: processor and downstream masters issuing decode requests
`timescale 1ns/10ps
`default_nettype none
module ssd_cpu_model (
   input  wire logic                 clk,
   input  wire logic                 rst,
   input  wire ssd_pkg::ssd_req_type cmd,
   output var  ssd_pkg::ssd_req_type req
);
   ssd_pkg::ssd_req_type next_req;

   always_comb begin
      // no request carries a cacheable mark or a translated aperture address
      next_req = cmd;
      // idle bus does not keep the last address
      if (!cmd.valid)
         next_req.addr = ~req.addr;
   end

   always_ff @(posedge clk) begin
      if (rst)
         req <= '0;
      else
         req <= next_req;
   end
endmodule
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the management memory decoder
`timescale 1ns/10ps
`default_nettype none
`define SSD_CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench;
   logic                  clk, rst, s_axi_awvalid, s_axi_awready;
   logic                  s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic                  s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                  s_axi_rvalid, s_axi_rready;
   logic [7:0]            s_axi_awaddr, s_axi_araddr, n_dram, n_ref;
   logic [31:0]           s_axi_wdata, s_axi_rdata, ctrl, top, stolen;
   logic [31:0]           seed, rd, te, sz, a, x, y;
   logic [3:0]            s_axi_wstrb;
   logic [1:0]            s_axi_bresp, s_axi_rresp, rs;
   int                    fails, tests_run;
   ssd_pkg::ssd_req_type  cmd, req, r;
   ssd_pkg::ssd_resp_type resp;

   ssd_decode uut (
      .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .req, .resp
   );
   ssd_cpu_model cpu (.clk, .rst, .cmd, .req);

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [2:0] exp_dest(ssd_pkg::ssd_req_type q);
      logic c, h, t, en, ok;
      logic [2:0] fwd;
      c = q.addr >= ssd_pkg::COMPAT_LO && q.addr <= ssd_pkg::COMPAT_HI;
      h = q.addr >= ssd_pkg::HIGH_LO && q.addr <= ssd_pkg::HIGH_HI;
      t = q.addr >= te - sz && q.addr < te;
      en = ctrl[0] && (c && !ctrl[1] || h && ctrl[1] || t && ctrl[2]);
      ok = ctrl[5] ? q.in_mgmt_mode : ctrl[4] || q.in_mgmt_mode;
      fwd = (ctrl[6] && !ctrl[7]) ? ssd_pkg::SSD_DEST_PEG
                                  : ssd_pkg::SSD_DEST_SOUTH;
      if (en && !q.from_cpu)
         return ssd_pkg::SSD_DEST_REFUSE;
      if (c && ctrl[0] && ctrl[1])
         return fwd;
      if (!en || (q.request_type_bit1 && !ok))
         return ssd_pkg::SSD_DEST_NORMAL;
      if (q.request_type_bit1 && ctrl[3] && q.in_mgmt_mode && !q.is_code)
         return t ? ssd_pkg::SSD_DEST_NORMAL : fwd;
      return ssd_pkg::SSD_DEST_DRAM;
   endfunction

   task automatic axw(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      s_axi_awaddr  <= ad;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      rs = s_axi_bresp;
   endtask

   task automatic axr(input logic [7:0] ad);
      @(posedge clk);
      s_axi_araddr  <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
   endtask

   task automatic send(input ssd_pkg::ssd_req_type q, input logic [2:0] d);
      logic [31:0] da;
      da = q.addr;
      if (q.addr >= ssd_pkg::HIGH_LO && q.addr <= ssd_pkg::HIGH_HI)
         da = q.addr - ssd_pkg::HIGH_OFFSET;
      @(posedge clk);
      cmd <= q;
      @(posedge clk);
      cmd.valid <= 1'b0;
      @(posedge clk);
      #1;
      `SSD_CHK(resp.valid, 1'b1)
      `SSD_CHK(resp.dest, d)
      if (d == ssd_pkg::SSD_DEST_DRAM)
         `SSD_CHK(resp.dram_addr, da)
      n_dram += 8'(d == ssd_pkg::SSD_DEST_DRAM);
      n_ref += 8'(d == ssd_pkg::SSD_DEST_REFUSE);
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #80000;
      fails++;
      finish_test();
   end

   initial begin
      rst = 1'b1;
      cmd = '0;
      seed = 32'h0000_022f;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hf;
      {fails, tests_run, n_dram, n_ref} = '0;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 17; k++) begin
         if (k < 9 || k > 11) begin
            axr(8'(4 * k));
            `SSD_CHK(rd, 32'h0)
            `SSD_CHK(rs, ssd_pkg::RESP_OKAY)
         end
      end
      axr(8'h80);
      `SSD_CHK(rs, ssd_pkg::RESP_SLVERR)
      axr(ssd_pkg::REG_WIN_LAST);
      `SSD_CHK(rs, ssd_pkg::RESP_SLVERR)
      axw(8'h80, 32'hffff_ffff);
      `SSD_CHK(rs, ssd_pkg::RESP_SLVERR)
      $display("test registers finished");
      for (int i = 0; i < 400; i++) begin
         if (i % 8 == 0) begin
            ctrl = rnd() & 32'h0000_07fe;
            ctrl[0] = (i % 64 != 0);
            // open and close never together
            if (ctrl[4])
               ctrl[3] = 1'b0;
            top = (rnd() & 32'h3ff0_0000) | 32'h0200_0000;
            stolen = rnd() & 32'h00f0_0000;
            te = top - (ctrl[8] ? stolen : 32'h0);
            sz = ctrl[10:9] == 2'd0 ? ssd_pkg::MB_1 :
                 ctrl[10:9] == 2'd1 ? ssd_pkg::MB_2 : ssd_pkg::MB_8;
            axw(ssd_pkg::REG_CTRL, ctrl);
            `SSD_CHK(rs, ssd_pkg::RESP_OKAY)
            axw(ssd_pkg::REG_TOP, top);
            axw(ssd_pkg::REG_STOLEN, stolen);
            axr(ssd_pkg::REG_CTRL);
            `SSD_CHK(rd, ctrl)
         end
         x = rnd();
         y = rnd();
         case (x[1:0])
            2'd0: a = ssd_pkg::COMPAT_LO - 32'h1 + 32'(y[17:0]);
            2'd1: a = ssd_pkg::HIGH_LO - 32'h1 + 32'(y[17:0]);
            2'd2: a = te - 32'h0090_0000 + 32'(y[23:0]);
            default: a = te - 32'(y[0]) - (y[1] ? sz : 32'h0);
         endcase
         r = '{1'b1, a, |x[29:28], x[30], x[31], |x[27:26]};
         if (x[1:0] == 2'd0 && ctrl[1])
            r.from_cpu = 1'b1;
         send(r, exp_dest(r));
      end
      axr(ssd_pkg::REG_STATUS);
      `SSD_CHK(rd[15:0], {n_ref, n_dram})
      axw(ssd_pkg::REG_STATUS, 32'h0);
      axr(ssd_pkg::REG_STATUS);
      `SSD_CHK(rd[15:0], {n_ref, n_dram})
      $display("test decode finished");
      axw(ssd_pkg::REG_CTRL, 32'h0000_0100);
      for (int w = 0; w < ssd_pkg::NUM_WIN; w++) begin
         a = 32'hc000_0000 + (32'(w) << 24);
         axw(ssd_pkg::REG_WIN_BASE + 8'(4 * w), a);
         axw(ssd_pkg::REG_WIN_MASK + 8'(4 * w), 32'hff00_0000);
         axr(ssd_pkg::REG_WIN_MASK + 8'(4 * w));
         `SSD_CHK(rd, 32'hff00_0000)
         r = '{1'b1, a | (rnd() & 32'h00ff_fffc), 1'b1, 1'b0, 1'b0, 1'b1};
         send(r, ssd_pkg::SSD_DEST_GFX);
         `SSD_CHK(resp.window_hit, 3'(w))
         `SSD_CHK(resp.write_combining_attr, w == ssd_pkg::WIN_APERTURE)
      end
      axw(ssd_pkg::REG_CTRL, 32'h0);
      send(r, ssd_pkg::SSD_DEST_NORMAL);
      $display("test windows finished");
      finish_test();
   end
endmodule
`default_nettype wire
